// ===== common/ftd_pkg.sv
package ftd_pkg;

    localparam int          DIV_W          = 6;
    localparam int          REG_W          = 8;
    localparam int          ADDR_W         = 4;

    // Byte addresses on the register bus
    localparam logic [3:0]  OFS_DIVIDER    = 4'h0;
    localparam logic [3:0]  OFS_CONTROL    = 4'h4;
    localparam logic [3:0]  OFS_STATUS     = 4'h8;

    // Field positions in the divider register
    localparam int          LOADED_POS     = 7;
    localparam int          LOCK_POS       = 6;

    // Field positions in control and status registers
    localparam int          SPECIAL_POS    = 0;
    localparam int          CMD_DONE_POS   = 0;
    localparam int          TICK_SEEN_POS  = 1;

    // Values after reset
    localparam logic [5:0]  DIV_RESET      = 6'h00;
    localparam logic        LOCK_RESET     = 1'b0;
    localparam logic        LOADED_RESET   = 1'b0;
    localparam logic        SPECIAL_RESET  = 1'b0;

    // Timebase target and the bus clock it assumes
    localparam int          TIMEBASE_HZ    = 1000000;
    localparam int          BUS_CLK_HZ     = 200000000;
    localparam logic [31:0] UNMAPPED_VALUE = 32'h0000_0000;

    // Bus phases of the slave
    typedef enum logic [2:0] {
        FTD_IDLE  = 3'b001,
        FTD_WRITE = 3'b010,
        FTD_READ  = 3'b100
    } ftd_phase_t;

    // Divider register contents
    typedef struct packed {
        logic       loaded;
        logic       lock;
        logic [5:0] ratio;
    } ftd_divider_t;

    // Avalon request bundle
    typedef struct packed {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } ftd_req_t;

endpackage

// ===== core/ftd_tick_gen.sv
`timescale 1ns/100ps
`default_nettype none

module ftd_tick_gen #(
    parameter int DIV_W = 6
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [DIV_W-1:0] ratio,
    output logic                  tick
);
    import ftd_pkg::*;

    logic [DIV_W-1:0] count_reg;
    logic [DIV_W-1:0] count_next;
    logic             tick_next;
    wire              wrap;

    // Count runs 0..ratio so one tick per ratio+1 cycles
    assign wrap       = (count_reg >= ratio);
    assign count_next = wrap ? '0 : count_reg + 1'b1;
    assign tick_next  = wrap;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
            tick      <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick      <= tick_next;
        end
    end
endmodule // ftd_tick_gen

`default_nettype wire

// ===== core/ftd_divider.sv
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Reads return every current bit of the divider register.
// - Software writes to the loaded flag, bit 7, are ignored always.
// - Normal mode: lock bit is write-once-high and gates divide writes.
// - Special mode: bits 6..0 freely writable, lock clearable, bit 7 not.
// - Any divider write with byte lane 0 enabled sets the loaded flag; only reset clears it.
// - Normal mode: lock stays set until reset, which restores writability.
// - Normal mode with lock set: divide field writes are discarded.
// - Divide field divides the bus clock by ratio+1 (1 to 64); no setting reaches 1 MHz from 200 MHz.

module ftd_divider #(
    parameter int DIV_W = ftd_pkg::DIV_W
) (
    input  wire logic                    clock,
    input  wire logic                    rst,
    input  wire logic [ftd_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [3:0]              avs_byteenable,
    input  wire logic [31:0]             avs_writedata,
    output logic      [31:0]             avs_readdata,
    output logic                         avs_waitrequest,
    output logic                         avs_readdatavalid,
    input  wire logic                    command_complete_flag,
    output logic                         timebase_tick,
    output logic      [DIV_W-1:0]        divide_ratio_field,
    output logic                         divider_lock_bit,
    output logic                         divider_loaded_flag
);
    import ftd_pkg::*;

    ftd_req_t     req;
    ftd_phase_t   phase_reg;
    ftd_phase_t   phase_next;
    ftd_divider_t div_reg;
    ftd_divider_t div_next;
    logic         special_reg;
    logic         special_next;
    logic         tick_seen_reg;
    logic         tick_seen_next;
    logic [31:0]  rdata_reg;
    logic [31:0]  rdata_next;
    logic         rvalid_reg;
    logic         tick_raw;

    wire          sel_div;
    wire          sel_ctl;
    wire          sel_sts;
    wire          low_lane;
    wire          wr_div;
    wire          wr_ctl;
    wire          rd_sts;
    wire          ratio_open;
    wire          lock_open;
    wire  [7:0]   wbyte;
    wire  [31:0]  div_word;
    wire  [31:0]  ctl_word;
    wire  [31:0]  sts_word;
    wire  [31:0]  read_mux;

    assign req = '{address: avs_address, read: avs_read,
                   write: avs_write, byteenable: avs_byteenable,
                   writedata: avs_writedata};

    assign sel_div  = (req.address == OFS_DIVIDER);
    assign sel_ctl  = (req.address == OFS_CONTROL);
    assign sel_sts  = (req.address == OFS_STATUS);
    assign low_lane = req.byteenable[0];
    assign wbyte    = req.writedata[7:0];

    // Write acts in the one cycle the request is accepted
    assign wr_div = (phase_reg == FTD_WRITE) && sel_div && low_lane;
    assign wr_ctl = (phase_reg == FTD_WRITE) && sel_ctl && low_lane;
    assign rd_sts = (phase_reg == FTD_READ) && sel_sts;

    // Divide field open unless locked in normal mode
    assign ratio_open = special_reg || !div_reg.lock;
    // Lock only rises in normal mode, any value in special
    assign lock_open  = special_reg || !div_reg.lock;

    always_comb begin
        div_next = div_reg;
        if (wr_div) begin
            div_next.loaded = 1'b1;
            if (ratio_open) begin
                div_next.ratio = wbyte[DIV_W-1:0];
            end
            if (lock_open) begin
                div_next.lock = wbyte[LOCK_POS];
            end
        end
    end

    assign special_next = wr_ctl ? wbyte[SPECIAL_POS] : special_reg;
    // Set beats the read-clear so a tick is never lost
    assign tick_seen_next = tick_raw | (tick_seen_reg & ~rd_sts);

    assign div_word = {24'h000000, div_reg};
    assign ctl_word = {31'h00000000, special_reg};
    assign sts_word = {30'h00000000, tick_seen_reg, command_complete_flag};
    assign read_mux = sel_div ? div_word :
                      sel_ctl ? ctl_word :
                      sel_sts ? sts_word : UNMAPPED_VALUE;
    assign rdata_next = (phase_reg == FTD_READ) ? read_mux : rdata_reg;

    // One wait cycle, then accept; readdata comes from the read mux in the accept cycle and is held after
    always_comb begin
        case (phase_reg)
            FTD_IDLE: begin
                if (req.write) begin
                    phase_next = FTD_WRITE;
                end else if (req.read) begin
                    phase_next = FTD_READ;
                end else begin
                    phase_next = FTD_IDLE;
                end
            end
            FTD_WRITE: phase_next = FTD_IDLE;
            FTD_READ:  phase_next = FTD_IDLE;
            default:   phase_next = FTD_IDLE;
        endcase
    end

    assign avs_waitrequest = (req.read || req.write) &&
                             (phase_reg == FTD_IDLE);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            phase_reg     <= FTD_IDLE;
            div_reg       <= '{loaded: LOADED_RESET, lock: LOCK_RESET,
                               ratio: DIV_RESET};
            special_reg   <= SPECIAL_RESET;
            tick_seen_reg <= 1'b0;
            rdata_reg     <= 32'h00000000;
            rvalid_reg    <= 1'b0;
        end else begin
            phase_reg     <= phase_next;
            div_reg       <= div_next;
            special_reg   <= special_next;
            tick_seen_reg <= tick_seen_next;
            rdata_reg     <= rdata_next;
            rvalid_reg    <= (phase_reg == FTD_READ);
        end
    end

    // Rate assumes software chose the ratio for the bus clock
    ftd_tick_gen #(
        .DIV_W (DIV_W)
    ) u_tick (
        .clock (clock),
        .rst   (rst),
        .ratio (div_reg.ratio),
        .tick  (tick_raw)
    );

    assign avs_readdata        = rdata_next;
    assign avs_readdatavalid   = rvalid_reg;
    assign timebase_tick       = tick_raw;
    assign divide_ratio_field  = div_reg.ratio;
    assign divider_lock_bit    = div_reg.lock;
    assign divider_loaded_flag = div_reg.loaded;
endmodule // ftd_divider

`default_nettype wire

// ===== verif/ftd_divider_chk.sv
`timescale 1ns/100ps
`default_nettype none
module ftd_divider_chk
    import ftd_pkg::*;
#(
    parameter int DIV_W = 6
) (
    input wire logic              clock,
    input wire logic              rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [3:0]        avs_byteenable,
    input wire logic [31:0]       avs_writedata,
    input wire logic [31:0]       avs_readdata,
    input wire logic              avs_waitrequest,
    input wire logic              timebase_tick,
    input wire logic [DIV_W-1:0]  divide_ratio_field,
    input wire logic              divider_lock_bit,
    input wire logic              divider_loaded_flag
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire logic       hit = avs_address == OFS_DIVIDER && !avs_waitrequest;
    wire logic       wr = hit && avs_write && avs_byteenable[0];
    logic [DIV_W:0]  gap_reg;
    logic            clean_reg;
    // Period judged only after a tick under an unchanged ratio
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gap_reg <= '0;
            clean_reg <= 1'b0;
        end else begin
            gap_reg <= timebase_tick ? '0 : gap_reg + 1'b1;
            if ($changed(divide_ratio_field))
                clean_reg <= 1'b0;
            else if (timebase_tick)
                clean_reg <= 1'b1;
        end
    end
    AST_READ_ALL: assert property (hit && avs_read |->
        avs_readdata == {24'h0, divider_loaded_flag, divider_lock_bit,
        divide_ratio_field}) else $error("bad divider read");
    AST_LOADED_SET: assert property (wr |=> divider_loaded_flag)
        else $error("loaded flag not set");
    AST_LOADED_HOLD: assert property (!$fell(divider_loaded_flag))
        else $error("loaded flag cleared");
    AST_RATIO_CAUSE: assert property ($changed(divide_ratio_field)
        |-> $past(wr)) else $error("ratio changed without write");
    AST_RATIO_TAKE: assert property (wr && !divider_lock_bit |=>
        divide_ratio_field == $past(avs_writedata[DIV_W-1:0]))
        else $error("open write not taken");
    AST_LOCK_SET: assert property (wr && avs_writedata[LOCK_POS]
        |=> divider_lock_bit) else $error("lock not set");
    AST_LOCK_FALL: assert property ($fell(divider_lock_bit) |->
        $past(wr && !avs_writedata[LOCK_POS])) else $error("lock lost");
    AST_TICK_EXACT: assert property (clean_reg && timebase_tick
        && $stable(divide_ratio_field) |-> gap_reg == divide_ratio_field)
        else $error("tick early");
    AST_TICK_LATE: assert property (clean_reg
        && $stable(divide_ratio_field) |-> gap_reg <= divide_ratio_field)
        else $error("tick missing");
    C_LOCKED_WR: cover property (wr && divider_lock_bit);
    C_UNLOCK: cover property ($fell(divider_lock_bit));
    C_SLOW: cover property (clean_reg && timebase_tick && gap_reg > 1);
endmodule // ftd_divider_chk
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ftd_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  adr = 4'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [3:0]  be = 4'h1;
    logic [31:0] wd = 32'h0;
    logic        ccf = 1'b1;
    logic [31:0] q, rq;
    logic [7:0]  m = 8'h00, d;
    logic        sp = 1'b0, wt, tick, lock, ld;
    logic [5:0]  ratio;
    integer      seed = 32'he6dd;
    int          n_mismatch = 0, cmp_count = 0;
    always #2.5 clock = ~clock;
    ftd_divider i_dut (.clock(clock), .rst(rst), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_byteenable(be),
        .avs_writedata(wd), .avs_readdata(q), .avs_waitrequest(wt),
        .avs_readdatavalid(), .command_complete_flag(ccf),
        .timebase_tick(tick), .divide_ratio_field(ratio),
        .divider_lock_bit(lock), .divider_loaded_flag(ld));
    // Locked normal mode keeps lock and ratio; bit 7 is never taken
    function automatic logic [7:0] model(input logic [7:0] c, x);
        return (sp || !c[6]) ? {1'b1, x[6:0]} : {1'b1, c[6:0]};
    endfunction
    task automatic chk(input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic r, input logic [3:0] a, logic [7:0] x);
        int n;
        n = 0;
        adr <= a;
        rd <= r;
        wr <= !r;
        wd <= {24'h0, x};
        do @(posedge clock);
        while (wt !== 1'b0 && ++n < 50);
        // A slave that never answers counts against the run
        if (wt !== 1'b0)
            n_mismatch++;
        rq = q;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rchk;
        bus(1'b1, OFS_DIVIDER, 8'h00);
        chk(rq, {24'h0, m});
        chk({24'h0, ld, lock, ratio}, {24'h0, m});
    endtask
    task automatic wdiv(input logic [7:0] x);
        bus(1'b0, OFS_DIVIDER, x);
        m = model(m, x);
        rchk;
    endtask
    task automatic period(input int exp);
        int n;
        repeat (3) begin
            n = 0;
            do @(posedge clock);
            while (tick !== 1'b1 && ++n < 300);
        end
        chk(n + 1, exp);
    endtask
    task automatic close_out;
        $display("cmp_count %0d n_mismatch %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rchk;
        bus(1'b1, 4'hc, 8'h00);
        chk(rq, UNMAPPED_VALUE);
        period(1);
        repeat (12) wdiv(8'($random(seed)) & 8'hbf);
        be <= 4'h0;
        bus(1'b0, OFS_DIVIDER, 8'h2a);
        be <= 4'h1;
        rchk;
        d = 8'h40 | (8'($random(seed)) & 8'h07);
        wdiv(d);
        period(int'(d[2:0]) + 1);
        wdiv(8'h00);
        repeat (6) wdiv(8'($random(seed)));
        $display("done: normal mode");
        bus(1'b0, OFS_CONTROL, 8'h01);
        sp = 1'b1;
        wdiv(8'hc5);
        repeat (6) wdiv(8'($random(seed)));
        wdiv(8'h82);
        period(3);
        bus(1'b1, OFS_CONTROL, 8'h00);
        chk(rq, 32'h00000001);
        $display("done: special mode");
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        m = 8'h00;
        sp = 1'b0;
        rchk;
        wdiv(8'h12);
        period(19);
        ccf <= 1'b0;
        bus(1'b1, OFS_STATUS, 8'h00);
        chk(rq, 32'h00000002);
        ccf <= 1'b1;
        bus(1'b1, OFS_STATUS, 8'h00);
        chk(rq[0], 1'b1);
        $display("done: reset in run");
        close_out;
    end
    initial begin
        #50000;
        n_mismatch++;
        close_out;
    end
endmodule // tb
bind ftd_divider ftd_divider_chk #(.DIV_W(DIV_W)) u_chk (.clock(clock),
    .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .timebase_tick(timebase_tick),
    .divide_ratio_field(divide_ratio_field),
    .divider_lock_bit(divider_lock_bit),
    .divider_loaded_flag(divider_loaded_flag));
`default_nettype wire
